//--- hw/psir_pkg.sv
`default_nettype none
package psir_pkg;

	// ==========================================================
	// management register addresses
	localparam logic [4:0]  REG_CTRL       = 5'h00;
	localparam logic [4:0]  REG_STAT       = 5'h01;
	localparam logic [4:0]  REG_ID1        = 5'h02;
	localparam logic [4:0]  REG_ID2        = 5'h03;
	localparam logic [4:0]  REG_ADV        = 5'h04;

	// ==========================================================
	// control word: reset bit and read-back of fixed defaults
	localparam int          CTRL_RESET_BIT = 15;
	localparam logic [15:0] CTRL_DEFAULT   = 16'h1140;

	// ==========================================================
	// status word: constant ability bits and live field positions
	localparam logic [15:0] STAT_FIXED     = 16'h7949;
	localparam int          STAT_AN_DONE   = 5;
	localparam int          STAT_RFAULT    = 4;
	localparam int          STAT_LINK      = 2;
	localparam int          STAT_JABBER    = 1;

	// ==========================================================
	// advertisement word: reset value and writable bits
	localparam logic [15:0] ADV_RESET      = 16'h01e1;
	localparam logic [15:0] ADV_WR_MASK    = 16'hadff;

	// ==========================================================
	// serial management frame
	localparam logic [1:0]  OP_READ        = 2'h2;
	localparam logic [1:0]  OP_WRITE       = 2'h1;
	localparam logic [3:0]  HDR_LAST       = 4'hb;
	localparam logic [3:0]  DATA_LAST      = 4'hf;

	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          PHY_RESET_NS   = 1000;
	localparam int          PHY_RESET_CYC  = (PHY_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RST_CNT_W      = 8;
	localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(PHY_RESET_CYC - 1);

	// ==========================================================
	// carriers
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  regad;
		logic [15:0] wdata;
	} psir_mgmt_req_t;

	typedef struct packed {
		logic an_complete;
		logic remote_fault;
		logic link_up;
		logic jabber;
	} psir_line_t;

	typedef enum logic [2:0] {
		PSIR_HUNT,
		PSIR_START,
		PSIR_HEADER,
		PSIR_TURN,
		PSIR_RDATA,
		PSIR_WDATA
	} psir_frame_st_t;

endpackage : psir_pkg
`default_nettype wire

//--- hw/psir_mdio_slave.sv
`timescale 1ns/1ps
`default_nettype none
module psir_mdio_slave (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// management pins
	input  wire logic                mdc,
	input  wire logic                mdio_in,
	output logic                     mdio_out,
	output logic                     mdio_oe,
	// register side
	input  wire logic [4:0]          phy_addr,
	input  wire logic [15:0]         rd_data,
	output psir_pkg::psir_mgmt_req_t req
);
	import psir_pkg::*;

	typedef struct packed {
		logic           mdc_s1;
		logic           mdc_s2;
		logic           mdc_s3;
		logic           dat_s1;
		logic           dat_s2;
		psir_frame_st_t st;
		logic [3:0]     cnt;
		logic           is_rd;
		logic [15:0]    sh;
		logic           out;
		logic           oe;
		psir_mgmt_req_t req;
	} psir_slave_q_t;

	psir_slave_q_t q;
	psir_slave_q_t next_q;

	// ==========================================================
	// frame engine
	// frames may start straight at the start bits, preamble or not
	always_comb begin
		next_q = q;
		next_q.mdc_s1 = mdc;
		next_q.mdc_s2 = q.mdc_s1;
		next_q.mdc_s3 = q.mdc_s2;
		next_q.dat_s1 = mdio_in;
		next_q.dat_s2 = q.dat_s1;
		next_q.req.rd = 1'b0;
		next_q.req.wr = 1'b0;
		// snapshot of the addressed word, one cycle after the request
		if (q.req.rd) begin
			next_q.sh = rd_data;
		end
		if (q.mdc_s2 && !q.mdc_s3) begin
			unique case (q.st)
				PSIR_HUNT: begin
					if (!q.dat_s2) next_q.st = PSIR_START;
				end
				PSIR_START: begin
					if (q.dat_s2) begin
						next_q.st = PSIR_HEADER;
						next_q.cnt = 4'h0;
					end
				end
				PSIR_HEADER: begin
					next_q.sh = {q.sh[14:0], q.dat_s2};
					next_q.cnt = q.cnt + 4'h1;
					if (q.cnt == HDR_LAST) begin
						next_q.cnt = 4'h0;
						next_q.st = PSIR_HUNT;
						next_q.req.regad = next_q.sh[4:0];
						if (next_q.sh[9:5] == phy_addr && next_q.sh[11:10] == OP_READ) begin
							next_q.is_rd = 1'b1;
							next_q.req.rd = 1'b1;
							next_q.st = PSIR_TURN;
						end else if (next_q.sh[9:5] == phy_addr && next_q.sh[11:10] == OP_WRITE) begin
							next_q.is_rd = 1'b0;
							next_q.st = PSIR_TURN;
						end
					end
				end
				PSIR_TURN: begin
					if (q.cnt == 4'h0) begin
						next_q.cnt = 4'h1;
						next_q.oe = q.is_rd;
						next_q.out = 1'b0;
					end else begin
						next_q.cnt = 4'h0;
						if (q.is_rd) begin
							next_q.out = q.sh[15];
							next_q.sh = {q.sh[14:0], 1'b0};
							next_q.st = PSIR_RDATA;
						end else begin
							next_q.st = PSIR_WDATA;
						end
					end
				end
				PSIR_RDATA: begin
					if (q.cnt == DATA_LAST) begin
						next_q.oe = 1'b0;
						next_q.out = 1'b0;
						next_q.st = PSIR_HUNT;
					end else begin
						next_q.out = q.sh[15];
						next_q.sh = {q.sh[14:0], 1'b0};
						next_q.cnt = q.cnt + 4'h1;
					end
				end
				PSIR_WDATA: begin
					next_q.sh = {q.sh[14:0], q.dat_s2};
					next_q.cnt = q.cnt + 4'h1;
					if (q.cnt == DATA_LAST) begin
						next_q.req.wr = 1'b1;
						next_q.req.wdata = next_q.sh;
						next_q.st = PSIR_HUNT;
					end
				end
				default: next_q.st = PSIR_HUNT;
			endcase
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign mdio_out = q.out;
	assign mdio_oe  = q.oe;
	assign req      = q.req;

endmodule : psir_mdio_slave
`default_nettype wire

//--- hw/psir_status_id_regs.sv
`timescale 1ns/1ps
`default_nettype none
module psir_status_id_regs #(
	parameter logic [15:0] OUI_ID_HI = 16'h2a5c, // arbitrary value
	parameter logic [5:0]  OUI_ID_LO = 6'h15,    // arbitrary value
	parameter logic [5:0]  MODEL_NUM = 6'h09,    // arbitrary value
	parameter logic [3:0]  REV_NUM   = 4'h3      // arbitrary value
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// management pins
	input  wire logic                mdc,
	input  wire logic                mdio_in,
	output logic                     mdio_out,
	output logic                     mdio_oe,
	// configuration
	input  wire logic [4:0]          phy_addr,
	// live line state from the link logic
	input  wire psir_pkg::psir_line_t line,
	// controls to the rest of the PHY
	output logic                     an_restart,
	output logic                     phy_reset,
	output logic [15:0]              adv_word
);
	import psir_pkg::*;

	typedef struct packed {
		logic                 rf;
		logic                 jab;
		logic                 link;
		logic [15:0]          adv;
		logic                 busy;
		logic [RST_CNT_W-1:0] rcnt;
		logic                 restart;
	} psir_regs_q_t;

	psir_regs_q_t   q;
	psir_regs_q_t   next_q;
	psir_mgmt_req_t req;
	logic [15:0]    rd_data;
	logic           stat_rd;
	logic           wr_adv;
	logic           wr_ctrl;

	// ==========================================================
	// status word assembly
	function automatic logic [15:0] psir_status(input logic an, input logic rf,
			input logic link, input logic jab);
		logic [15:0] w;
		w = STAT_FIXED;
		w[STAT_AN_DONE] = an;
		w[STAT_RFAULT] = rf;
		w[STAT_LINK] = link;
		w[STAT_JABBER] = jab;
		return w;
	endfunction : psir_status

	// ==========================================================
	// serial management port
	psir_mdio_slave u_slave (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.phy_addr (phy_addr),
		.rd_data  (rd_data),
		.req      (req)
	);

	// access decode
	assign stat_rd = req.rd && req.regad == REG_STAT;
	assign wr_adv  = req.wr && req.regad == REG_ADV;
	assign wr_ctrl = req.wr && req.regad == REG_CTRL;

	// ==========================================================
	// read mux; unmapped addresses read zero
	always_comb begin
		unique case (req.regad)
			REG_CTRL: rd_data = {q.busy, CTRL_DEFAULT[14:0]};
			REG_STAT: rd_data = psir_status(line.an_complete, q.rf, q.link, q.jab);
			REG_ID1:  rd_data = OUI_ID_HI;
			REG_ID2:  rd_data = {OUI_ID_LO, MODEL_NUM, REV_NUM};
			REG_ADV:  rd_data = q.adv;
			default:  rd_data = 16'h0000;
		endcase
	end

	// ==========================================================
	// latches, advertisement and soft reset
	// status and identifier writes have no path into any state
	always_comb begin
		next_q = q;
		next_q.restart = 1'b0;
		// a read clears in the capture cycle; a new event wins
		next_q.rf = (q.rf && !stat_rd) || line.remote_fault;
		next_q.jab = (q.jab && !stat_rd) || line.jabber;
		next_q.link = stat_rd ? line.link_up : (q.link && line.link_up);
		// only a management write or a soft reset changes the advertisement
		if (wr_adv) begin
			next_q.adv = req.wdata & ADV_WR_MASK;
			next_q.restart = !line.an_complete;
		end
		// reset runs for a fixed span, then the bit clears itself
		if (q.busy) begin
			if (q.rcnt == RST_LAST) begin
				next_q.busy = 1'b0;
			end else begin
				next_q.rcnt = q.rcnt + 1'b1;
			end
			next_q.rf = 1'b0;
			next_q.jab = 1'b0;
			next_q.link = 1'b0;
			next_q.adv = ADV_RESET;
			next_q.restart = 1'b0;
		end
		if (wr_ctrl && req.wdata[CTRL_RESET_BIT]) begin
			next_q.busy = 1'b1;
			next_q.rcnt = '0;
		end
	end

	// state register
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			q <= '{rf: 1'b0, jab: 1'b0, link: 1'b0, adv: ADV_RESET, busy: 1'b0,
				rcnt: '0, restart: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign an_restart = q.restart;
	assign phy_reset  = q.busy;
	assign adv_word   = q.adv;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	localparam int RST_SPAN = PHY_RESET_CYC;

	property p_no_t4;
		stat_rd |-> !rd_data[15];
	endproperty
	a_no_t4: assert property (p_no_t4) else $error("four-pair bit set");

	property p_abilities;
		stat_rd |-> rd_data[14:11] == 4'hf;
	endproperty
	a_abilities: assert property (p_abilities) else $error("ability bits wrong");

	property p_no_t2;
		stat_rd |-> rd_data[10:9] == 2'h0;
	endproperty
	a_no_t2: assert property (p_no_t2) else $error("two-pair bits set");

	property p_ext_status;
		stat_rd |-> rd_data[8];
	endproperty
	a_ext_status: assert property (p_ext_status) else $error("extended status bit low");

	property p_reserved;
		stat_rd |-> !rd_data[7];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_no_preamble;
		stat_rd |-> rd_data[6] && rd_data[3] && rd_data[0];
	endproperty
	a_no_preamble: assert property (p_no_preamble) else $error("fixed one bits low");

	property p_an_done;
		stat_rd |-> rd_data[5] == line.an_complete;
	endproperty
	a_an_done: assert property (p_an_done) else $error("negotiation bit not live");

	sequence s_fault_seen;
		line.remote_fault && !q.busy;
	endsequence
	sequence s_quiet;
		!stat_rd && !q.busy;
	endsequence
	property p_rf_hold;
		s_fault_seen ##1 s_quiet |=> q.rf;
	endproperty
	a_rf_hold: assert property (p_rf_hold) else $error("remote fault not held");

	property p_link_low;
		!line.link_up ##1 (!stat_rd && !line.link_up) |=> !q.link;
	endproperty
	a_link_low: assert property (p_link_low) else $error("link bit not latched low");

	property p_jabber;
		line.jabber && !q.busy |=> q.jab;
	endproperty
	a_jabber: assert property (p_jabber) else $error("jabber not latched");

	property p_id_one;
		req.rd && req.regad == REG_ID1 |-> rd_data == OUI_ID_HI;
	endproperty
	a_id_one: assert property (p_id_one) else $error("first identifier wrong");

	property p_id_two;
		req.rd && req.regad == REG_ID2 |-> rd_data[9:0] == {MODEL_NUM, REV_NUM};
	endproperty
	a_id_two: assert property (p_id_two) else $error("model or revision wrong");

	property p_restart;
		wr_adv && !line.an_complete && !q.busy |=> an_restart ##1 !an_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("no negotiation restart");

	property p_adv_kept;
		!wr_adv && !q.busy |=> $stable(q.adv);
	endproperty
	a_adv_kept: assert property (p_adv_kept) else $error("advertisement changed");

	sequence s_reset_cmd;
		wr_ctrl && req.wdata[CTRL_RESET_BIT];
	endsequence
	property p_reset_clears;
		s_reset_cmd |=> q.busy ##1 (!q.rf && !q.jab && !q.link);
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear");

	property p_reset_ends;
		s_reset_cmd ##1 (!wr_ctrl)[*8] |-> ##[1:RST_SPAN] !q.busy;
	endproperty
	a_reset_ends: assert property (p_reset_ends) else $error("reset bit stuck");

	property p_set_wins;
		stat_rd && line.remote_fault && !q.busy |=> q.rf;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("fault lost at read");

	// ==========================================================
	// fixed bits and identifier fields, one check per field
	property p_an_able;
		stat_rd |-> rd_data[3];
	endproperty
	a_an_able: assert property (p_an_able) else $error("negotiation ability bit low");

	property p_ext_set;
		stat_rd |-> rd_data[0];
	endproperty
	a_ext_set: assert property (p_ext_set) else $error("extended capability bit low");

	property p_oui_low;
		req.rd && req.regad == REG_ID2 |-> rd_data[15:10] == OUI_ID_LO;
	endproperty
	a_oui_low: assert property (p_oui_low) else $error("second identifier code bits wrong");

	// ==========================================================
	// latches hold between reads; fault and jabber clear once captured, link reloads from the line
	property p_rf_kept;
		q.rf && !stat_rd && !q.busy |=> q.rf;
	endproperty
	a_rf_kept: assert property (p_rf_kept) else $error("remote fault dropped without read");

	property p_rf_read_clr;
		stat_rd && !line.remote_fault |=> !q.rf;
	endproperty
	a_rf_read_clr: assert property (p_rf_read_clr) else $error("remote fault not cleared by read");

	property p_jab_kept;
		q.jab && !stat_rd && !q.busy |=> q.jab;
	endproperty
	a_jab_kept: assert property (p_jab_kept) else $error("jabber dropped without read");

	property p_jab_read_clr;
		stat_rd && !line.jabber |=> !q.jab;
	endproperty
	a_jab_read_clr: assert property (p_jab_read_clr) else $error("jabber not cleared by read");

	property p_link_read;
		stat_rd && line.link_up && !q.busy |=> q.link;
	endproperty
	a_link_read: assert property (p_link_read) else $error("link bit not restored by read");

	// ==========================================================
	// advertisement, restart and soft reset behaviour
	property p_adv_write;
		wr_adv && !q.busy |=> q.adv == ($past(req.wdata) & ADV_WR_MASK);
	endproperty
	a_adv_write: assert property (p_adv_write) else $error("advertisement write lost");

	property p_restart_cause;
		an_restart |-> $past(wr_adv) && !$past(line.an_complete);
	endproperty
	a_restart_cause: assert property (p_restart_cause) else $error("restart without early write");

	property p_no_restart_done;
		wr_adv && line.an_complete |=> !an_restart;
	endproperty
	a_no_restart_done: assert property (p_no_restart_done) else $error("restart after completion");

	property p_ro_write;
		req.wr && (req.regad == REG_STAT || req.regad == REG_ID1 || req.regad == REG_ID2) && !q.busy
			|=> $stable(q.adv) && !q.busy;
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write had an effect");

	property p_reset_adv;
		q.busy |=> q.adv == ADV_RESET;
	endproperty
	a_reset_adv: assert property (p_reset_adv) else $error("advertisement not reset");

	property p_busy_cause;
		$rose(q.busy) |-> $past(wr_ctrl) && $past(req.wdata[CTRL_RESET_BIT]);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("reset without command");

	property p_reset_len;
		q.busy && q.rcnt != RST_LAST |=> q.busy;
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("reset span cut short");

	property p_busy_done;
		q.busy && q.rcnt == RST_LAST && !wr_ctrl |=> !q.busy;
	endproperty
	a_busy_done: assert property (p_busy_done) else $error("reset bit did not self-clear");

endmodule : psir_status_id_regs
`default_nettype wire

//--- sim/psir_mgmt_master.sv
`timescale 1ns/1ps
`default_nettype none
module psir_mgmt_master (
	// clock
	input  wire logic sys_clk,
	// management pins
	output logic      mdc,
	output logic      mdio_in,
	input  wire logic mdio_out,
	input  wire logic mdio_oe
);
	logic host_oe;
	logic host_bit;

	// wire level: device, then host, else pull-up
	assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_bit : 1'b1);

	// idle: clock parked low, data released
	initial begin
		mdc = 1'b0;
		host_oe = 1'b0;
		host_bit = 1'b1;
	end

	// =====
	// one frame; pre preamble ones, none allowed
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, input int pre, output logic [15:0] rd, output logic ta0);
		logic [31:0] fr;
		fr = {2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		ta0 = 1'b1;
		for (int i = -pre; i < 32; i++) begin
			mdc = 1'b0;
			host_oe = (i < 14) || (op == 2'h1); // host lets go of the wire at turnaround on reads
			host_bit = 1'b1;
			if (i >= 0) begin
				host_bit = fr[31-i];
			end
			repeat (4) @(posedge sys_clk);
			#1;
			// sample just before the rise: device bit launched after the previous rise
			if (i == 15) begin
				ta0 = mdio_in;
			end
			if (i >= 16) begin
				rd[31-i] = mdio_in;
			end
			mdc = 1'b1;
			repeat (4) @(posedge sys_clk);
			#1;
		end
		mdc = 1'b0;
		host_oe = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : xfer
endmodule : psir_mgmt_master
`default_nettype wire

//--- sim/psir_status_id_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module psir_status_id_regs_tb_top;
	import psir_pkg::*;
	localparam logic [4:0] PA = 5'h05;
	logic        sys_clk, rst, mdc, mdio_in, mdio_out, mdio_oe;
	logic        an_restart, phy_reset, ta0;
	logic [15:0] adv_word, v;
	psir_line_t  line;
	int          n_mismatch, cmp_count, n_restart, rst_len, cyc;

	psir_status_id_regs #(.OUI_ID_HI(16'h3b71), .OUI_ID_LO(6'h2e), .MODEL_NUM(6'h11), .REV_NUM(4'h6))
	i_psir_status_id_regs (.sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .phy_addr(PA), .line(line), .an_restart(an_restart), .phy_reset(phy_reset),
		.adv_word(adv_word));
	psir_mgmt_master i_psir_mgmt_master (.sys_clk(sys_clk), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe));

	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// restart pulses, soft reset span and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (an_restart === 1'b1) n_restart++;
		if (phy_reset === 1'b1) rst_len++;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// =====
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		$display("counts: mismatches=%0d compares=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test

	function automatic logic [15:0] exp_stat(input logic an, input logic rf, input logic lk, input logic jb);
		return {1'b0, 4'hf, 2'b00, 1'b1, 1'b0, 1'b1, an, rf, 1'b1, lk, jb, 1'b1};
	endfunction : exp_stat

	task automatic rd_reg(input logic [4:0] ra, input int pre);
		i_psir_mgmt_master.xfer(OP_READ, PA, ra, 16'h0000, pre, v, ta0);
		chk({15'h0000, ta0}, 16'h0000);
	endtask : rd_reg

	task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
		i_psir_mgmt_master.xfer(OP_WRITE, PA, ra, wd, 32, v, ta0);
	endtask : wr_reg

	// =====
	task automatic t_status();
		rd_reg(5'h01, 32);
		rd_reg(5'h01, 0);
		chk(v, exp_stat(1'b1, 1'b0, 1'b1, 1'b0));
		line.an_complete = 1'b0;
		rd_reg(5'h01, 0);
		chk(v, exp_stat(1'b0, 1'b0, 1'b1, 1'b0));
	endtask : t_status

	task automatic t_latch();
		@(posedge sys_clk) #1;
		line = '{an_complete: 1'b0, remote_fault: 1'b1, link_up: 1'b0, jabber: 1'b1};
		@(posedge sys_clk) #1;
		line = '{an_complete: 1'b0, remote_fault: 1'b0, link_up: 1'b1, jabber: 1'b0};
		repeat (3) @(posedge sys_clk);
		rd_reg(5'h01, 32);
		chk(v, exp_stat(1'b0, 1'b1, 1'b0, 1'b1));
		rd_reg(5'h01, 32);
		chk(v, exp_stat(1'b0, 1'b0, 1'b1, 1'b0));
	endtask : t_latch

	task automatic t_ids();
		logic [15:0] e [1:3];
		e[1] = exp_stat(1'b0, 1'b0, 1'b1, 1'b0);
		e[2] = 16'h3b71;
		e[3] = {6'h2e, 6'h11, 4'h6};
		rd_reg(5'h02, 32);
		chk(v, e[2]);
		rd_reg(5'h03, 32);
		chk(v, e[3]);
		for (int r = 1; r < 4; r++) begin
			wr_reg(5'(r), ~e[r]);
			rd_reg(5'(r), 32);
			chk(v, e[r]);
		end
		// other address and unused op codes are never answered
		i_psir_mgmt_master.xfer(OP_READ, PA ^ 5'h01, 5'h01, 16'h0000, 32, v, ta0);
		chk(v, 16'hffff);
		i_psir_mgmt_master.xfer(2'h3, PA, 5'h01, 16'h0000, 32, v, ta0);
		chk(v, 16'hffff);
	endtask : t_ids

	task automatic t_adv();
		n_restart = 0;
		wr_reg(5'h04, 16'hffff);
		chk(adv_word, 16'hadff);
		chk(16'(n_restart), 16'h0001);
		line.an_complete = 1'b1;
		repeat (5) @(posedge sys_clk);
		chk(adv_word, 16'hadff);
		wr_reg(5'h04, 16'h0021);
		rd_reg(5'h04, 32);
		chk(v, 16'h0021);
		chk(16'(n_restart), 16'h0001);
	endtask : t_adv

	task automatic t_soft_reset();
		@(posedge sys_clk) #1;
		line.jabber = 1'b1;
		@(posedge sys_clk) #1;
		line.jabber = 1'b0;
		rst_len = 0;
		wr_reg(5'h00, 16'h8000);
		for (int k = 0; k < 400 && phy_reset !== 1'b0; k++) @(posedge sys_clk);
		#1;
		chk(16'(rst_len), 16'(PHY_RESET_CYC));
		chk(adv_word, 16'h01e1);
		rd_reg(5'h00, 32);
		chk(v, {1'b0, CTRL_DEFAULT[14:0]});
		rd_reg(5'h01, 32);
		chk(v, exp_stat(1'b1, 1'b0, 1'b0, 1'b0));
	endtask : t_soft_reset

	// =====
	// main sequence
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		n_restart = 0;
		rst_len = 0;
		cyc = 0;
		line = '{an_complete: 1'b1, remote_fault: 1'b0, link_up: 1'b1, jabber: 1'b0};
		rst = 1'b1;
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk(adv_word, 16'h01e1);
		chk({13'h0000, an_restart, phy_reset, mdio_oe}, 16'h0000);
		repeat (3) @(posedge sys_clk);
		#1;
		t_status();
		t_latch();
		t_ids();
		t_adv();
		t_soft_reset();
		finish_test();
	end
endmodule : psir_status_id_regs_tb_top
`default_nettype wire
